/* hdl/sdt_pkg.sv */
`default_nettype none
package sdt_pkg;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int NCH = 4;
    localparam int NTICK = 4;
    localparam int PRE_W = 4;
    localparam int STAT_W = 7;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] T0_CFG = 8'h00;
    localparam logic [7:0] T0_TGT = 8'h04;
    localparam logic [7:0] T0_CNT = 8'h08;
    localparam logic [7:0] T1_CFG = 8'h0C;
    localparam logic [7:0] T1_TGT = 8'h10;
    localparam logic [7:0] T1_CNT = 8'h14;
    localparam logic [7:0] T2_CFG = 8'h18;
    localparam logic [7:0] T2_TGT = 8'h1C;
    localparam logic [7:0] T2_CNT = 8'h20;
    localparam logic [7:0] CH_CFG0 = 8'h24;
    localparam logic [7:0] CH_VAL0 = 8'h34;
    localparam logic [7:0] IRQ_STAT = 8'h44;
    localparam logic [7:0] IRQ_MASK = 8'h48;
    localparam logic [7:0] REG_STRIDE = 8'h04;

    // Status bit positions
    localparam int ST_T0 = 0;
    localparam int ST_T1 = 1;
    localparam int ST_T2 = 2;
    localparam int ST_CH0 = 3;

    // Reset values
    localparam logic [CNT_W-1:0] TGT_RST = 16'hFFFF;
    localparam logic [CNT_W-1:0] ZERO_CNT = 16'h0000;

    typedef enum logic [1:0] {CLK_24M, CLK_2M, CLK_32K, CLK_OFF} t2_clk_e;

    // Bit 0 upward: en, oneshot, on_tick, tick_sel, pre_exp
    typedef struct packed {
        logic [PRE_W-1:0] pre_exp;
        logic [1:0] tick_sel;
        logic on_tick;
        logic oneshot;
        logic en;
    } tmr_cfg_s;

    // Bit 0 upward: en, oneshot, clk_sel, eng_ch, adc_ch
    typedef struct packed {
        logic [1:0] adc_ch;
        logic [1:0] eng_ch;
        t2_clk_e clk_sel;
        logic oneshot;
        logic en;
    } t2_cfg_s;

    // Bit 0 upward: en, capture, oneshot, toggle
    typedef struct packed {
        logic toggle;
        logic oneshot;
        logic capture;
        logic en;
    } ch_cfg_s;

    localparam int TCFG_W = $bits(tmr_cfg_s);
    localparam int T2CFG_W = $bits(t2_cfg_s);
    localparam int CHCFG_W = $bits(ch_cfg_s);
endpackage
`default_nettype wire

/* hdl/prescaled_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module prescaled_timer #(
    parameter int CNT_W = 16,
    parameter int NTICK = 4
) (
    input wire logic clk, // System clock
    input wire logic rst, // Sync reset, active high
    input wire sdt_pkg::tmr_cfg_s cfg, // Mode and prescaler
    input wire logic [CNT_W-1:0] target, // Terminal count
    input wire logic restart, // Config write, restarts the period
    input wire logic [NTICK-1:0] tick_in, // Tick sources
    output logic [CNT_W-1:0] count, // Current count
    output logic done, // One-shot finished
    output logic evt // Pulse at terminal count
);
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CNT_W-2:0] pre_r, pre_nxt, pre_mask;
    logic [NTICK-1:0] tick_r, tick_nxt;
    logic done_r, done_nxt;
    logic evt_r, evt_nxt;
    logic src_evt;

    assign count = cnt_r;
    assign done = done_r;
    assign evt = evt_r;

    always_comb begin
        tick_nxt = tick_in;
        pre_mask = (CNT_W-1)'((32'h1 << cfg.pre_exp) - 32'h1);
        src_evt = cfg.on_tick ?
            (tick_in[cfg.tick_sel] != tick_r[cfg.tick_sel]) : 1'b1;
        cnt_nxt = cnt_r;
        pre_nxt = pre_r;
        done_nxt = done_r;
        evt_nxt = 1'b0;
        if (restart || !cfg.en) begin
            cnt_nxt = '0;
            pre_nxt = '0;
            done_nxt = 1'b0;
        end else if (src_evt && !done_r) begin
            if (pre_r == pre_mask) begin
                pre_nxt = '0;
                if (cnt_r == target) begin
                    evt_nxt = 1'b1;
                    if (cfg.oneshot) begin
                        done_nxt = 1'b1;
                    end else begin
                        cnt_nxt = '0;
                    end
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end else begin
                pre_nxt = pre_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            pre_r <= '0;
            tick_r <= '0;
            done_r <= 1'b0;
            evt_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            pre_r <= pre_nxt;
            tick_r <= tick_nxt;
            done_r <= done_nxt;
            evt_r <= evt_nxt;
        end
    end
endmodule
`default_nettype wire

/* hdl/sensor_domain_timers.sv */
// Contract
// - Two 16-bit timers, each with a power-of-two prescaler.
// - Each advances on the clock or on every edge of a tick source.
// - Each supports one-shot (stop after a period) and periodic modes.
// - Third 16-bit timer clocked from 24 MHz, 2 MHz or 32 kHz source.
// - Third timer counts regardless of whether the engine is executing.
// - Third timer has four capture/compare channels, one-shot or periodic.
// - Third timer pulses engine and ADC events, drives PWM or waves.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sensor_domain_timers #(
    parameter int CNT_W = 16,
    parameter int NCH = 4,
    parameter int NTICK = 4
) (
    input wire logic clk, // 200 MHz system clock
    input wire logic rst, // Sync reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [NTICK-1:0] tick_src, // Tick sources, timers 0/1
    input wire logic en_24m, // 24 MHz enable strobe
    input wire logic en_2m, // 2 MHz enable strobe
    input wire logic en_32k, // 32 kHz enable strobe
    input wire logic [NCH-1:0] cap_in, // Capture inputs
    output logic ev_engine, // Event pulse to sensor engine
    output logic ev_adc, // Trigger pulse to ADC
    output logic [NCH-1:0] wave_out, // PWM or waveform outputs
    output logic irq // Level interrupt
);
    sdt_pkg::tmr_cfg_s tcfg_r [2];
    sdt_pkg::tmr_cfg_s tcfg_nxt [2];
    logic [CNT_W-1:0] ttgt_r [2];
    logic [CNT_W-1:0] ttgt_nxt [2];
    logic [CNT_W-1:0] tcnt [2];
    logic [1:0] tdone, tevt, twr;
    sdt_pkg::t2_cfg_s c2_r, c2_nxt;
    logic [CNT_W-1:0] t2tgt_r, t2tgt_nxt, t2cnt_r, t2cnt_nxt;
    logic t2done_r, t2done_nxt, t2tick, t2wrap, t2per;
    logic [NCH-1:0] chevt;
    logic [CNT_W-1:0] chval [NCH];
    sdt_pkg::ch_cfg_s chcfg [NCH];
    logic [sdt_pkg::STAT_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev_set;
    logic [31:0] prdata_r, prdata_nxt;
    logic evn_r, evn_nxt, eva_r, eva_nxt;
    logic wr, setup, mapped;

    assign wr = psel && penable && pwrite;
    assign setup = psel && !penable;
    // Every register answers at once, so the bus never waits
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;
    assign ev_engine = evn_r;
    assign ev_adc = eva_r;
    assign irq = |(stat_r & mask_r);

    // With four channels the map has no holes below the mask register
    always_comb begin
        mapped = (paddr[1:0] == 2'b00) && (paddr <= sdt_pkg::IRQ_MASK);
    end

    // Timers 0 and 1
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tmr
            // Timer 1's registers sit one block above timer 0's
            localparam logic [7:0] BASE =
                8'(g) * (sdt_pkg::T1_CFG - sdt_pkg::T0_CFG);
            always_comb begin
                twr[g] = wr && (paddr == sdt_pkg::T0_CFG + BASE);
                tcfg_nxt[g] = tcfg_r[g];
                ttgt_nxt[g] = ttgt_r[g];
                if (twr[g]) begin
                    tcfg_nxt[g] = sdt_pkg::tmr_cfg_s'(
                        pwdata[sdt_pkg::TCFG_W-1:0]);
                end
                if (wr && paddr == sdt_pkg::T0_TGT + BASE) begin
                    ttgt_nxt[g] = pwdata[CNT_W-1:0];
                end
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    tcfg_r[g] <= '0;
                    ttgt_r[g] <= sdt_pkg::TGT_RST;
                end else begin
                    tcfg_r[g] <= tcfg_nxt[g];
                    ttgt_r[g] <= ttgt_nxt[g];
                end
            end
            prescaled_timer #(
                .CNT_W(CNT_W),
                .NTICK(NTICK)
            ) u_tmr (
                .clk(clk),
                .rst(rst),
                .cfg(tcfg_r[g]),
                .target(ttgt_r[g]),
                .restart(twr[g]),
                .tick_in(tick_src),
                .count(tcnt[g]),
                .done(tdone[g]),
                .evt(tevt[g])
            );
        end
    endgenerate

    // Third timer base counter
    always_comb begin
        c2_nxt = c2_r;
        t2tgt_nxt = t2tgt_r;
        if (wr && paddr == sdt_pkg::T2_CFG) begin
            c2_nxt = sdt_pkg::t2_cfg_s'(pwdata[sdt_pkg::T2CFG_W-1:0]);
        end
        if (wr && paddr == sdt_pkg::T2_TGT) begin
            t2tgt_nxt = pwdata[CNT_W-1:0];
        end
        unique case (c2_r.clk_sel)
            sdt_pkg::CLK_24M: t2tick = en_24m;
            sdt_pkg::CLK_2M: t2tick = en_2m;
            sdt_pkg::CLK_32K: t2tick = en_32k;
            sdt_pkg::CLK_OFF: t2tick = 1'b0;
        endcase
        t2tick = t2tick && c2_r.en && !t2done_r;
        t2per = t2tick && (t2cnt_r == t2tgt_r);
        t2wrap = t2per && !c2_r.oneshot;
        t2cnt_nxt = t2cnt_r;
        t2done_nxt = t2done_r;
        if (!c2_r.en || (wr && paddr == sdt_pkg::T2_CFG)) begin
            t2cnt_nxt = sdt_pkg::ZERO_CNT;
            t2done_nxt = 1'b0;
        end else if (t2per) begin
            if (c2_r.oneshot) begin
                t2done_nxt = 1'b1;
            end else begin
                t2cnt_nxt = sdt_pkg::ZERO_CNT;
            end
        end else if (t2tick) begin
            t2cnt_nxt = t2cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            c2_r <= '0;
            t2tgt_r <= sdt_pkg::TGT_RST;
            t2cnt_r <= '0;
            t2done_r <= 1'b0;
        end else begin
            c2_r <= c2_nxt;
            t2tgt_r <= t2tgt_nxt;
            t2cnt_r <= t2cnt_nxt;
            t2done_r <= t2done_nxt;
        end
    end

    // Capture/compare channels
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            localparam logic [7:0] OFS = 8'(g) * sdt_pkg::REG_STRIDE;
            sdt_pkg::ch_cfg_s cfg_r, cfg_nxt;
            logic [CNT_W-1:0] val_r, val_nxt;
            logic arm_r, arm_nxt, cap_r, cap_nxt;
            logic out_r, out_nxt, evt_r, evt_nxt, hit;
            always_comb begin
                cfg_nxt = cfg_r;
                val_nxt = val_r;
                arm_nxt = arm_r;
                out_nxt = out_r;
                cap_nxt = cap_in[g];
                hit = 1'b0;
                if (cfg_r.capture) begin
                    hit = cap_in[g] && !cap_r;
                end else begin
                    hit = t2tick && (t2cnt_r == val_r);
                end
                hit = hit && cfg_r.en && arm_r;
                if (hit && cfg_r.capture) begin
                    val_nxt = t2cnt_r;
                end
                if (hit && !cfg_r.capture) begin
                    out_nxt = cfg_r.toggle ? !out_r : 1'b0;
                end else if (t2wrap && cfg_r.en && !cfg_r.capture
                        && !cfg_r.toggle) begin
                    out_nxt = 1'b1;
                end
                if (hit && cfg_r.oneshot) begin
                    arm_nxt = 1'b0;
                end
                if (wr && paddr == sdt_pkg::CH_VAL0 + OFS) begin
                    val_nxt = pwdata[CNT_W-1:0];
                end
                if (wr && paddr == sdt_pkg::CH_CFG0 + OFS) begin
                    cfg_nxt = sdt_pkg::ch_cfg_s'(
                        pwdata[sdt_pkg::CHCFG_W-1:0]);
                    arm_nxt = 1'b1;
                    out_nxt = 1'b0;
                end
                evt_nxt = hit;
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    cfg_r <= '0;
                    val_r <= '0;
                    arm_r <= 1'b0;
                    cap_r <= 1'b0;
                    out_r <= 1'b0;
                    evt_r <= 1'b0;
                end else begin
                    cfg_r <= cfg_nxt;
                    val_r <= val_nxt;
                    arm_r <= arm_nxt;
                    cap_r <= cap_nxt;
                    out_r <= out_nxt;
                    evt_r <= evt_nxt;
                end
            end
            assign chevt[g] = evt_r;
            assign chval[g] = val_r;
            assign chcfg[g] = cfg_r;
            assign wave_out[g] = out_r;
        end
    endgenerate

    // Event routing, status and read mux
    always_comb begin
        evn_nxt = chevt[c2_r.eng_ch] && c2_r.en;
        eva_nxt = chevt[c2_r.adc_ch] && c2_r.en;
        ev_set = '0;
        ev_set[sdt_pkg::ST_T0] = tevt[0];
        ev_set[sdt_pkg::ST_T1] = tevt[1];
        ev_set[sdt_pkg::ST_T2] = t2per;
        ev_set[sdt_pkg::ST_CH0 +: NCH] = chevt;
        mask_nxt = mask_r;
        if (wr && paddr == sdt_pkg::IRQ_MASK) begin
            mask_nxt = pwdata[sdt_pkg::STAT_W-1:0];
        end
        // Set wins over a same-cycle clear so no event is lost
        stat_nxt = stat_r;
        if (wr && paddr == sdt_pkg::IRQ_STAT) begin
            stat_nxt = stat_r & ~pwdata[sdt_pkg::STAT_W-1:0];
        end
        stat_nxt = stat_nxt | ev_set;
        // Captured at setup so the access phase sees a settled word
        prdata_nxt = prdata_r;
        if (setup && !pwrite) begin
            prdata_nxt = '0;
            unique case (paddr)
                sdt_pkg::T0_CFG: prdata_nxt[sdt_pkg::TCFG_W-1:0] = tcfg_r[0];
                sdt_pkg::T0_TGT: prdata_nxt[CNT_W-1:0] = ttgt_r[0];
                sdt_pkg::T0_CNT: prdata_nxt = {15'h0000, tdone[0], tcnt[0]};
                sdt_pkg::T1_CFG: prdata_nxt[sdt_pkg::TCFG_W-1:0] = tcfg_r[1];
                sdt_pkg::T1_TGT: prdata_nxt[CNT_W-1:0] = ttgt_r[1];
                sdt_pkg::T1_CNT: prdata_nxt = {15'h0000, tdone[1], tcnt[1]};
                sdt_pkg::T2_CFG: prdata_nxt[sdt_pkg::T2CFG_W-1:0] = c2_r;
                sdt_pkg::T2_TGT: prdata_nxt[CNT_W-1:0] = t2tgt_r;
                sdt_pkg::T2_CNT: prdata_nxt = {15'h0000, t2done_r, t2cnt_r};
                sdt_pkg::IRQ_STAT: prdata_nxt[sdt_pkg::STAT_W-1:0] = stat_r;
                sdt_pkg::IRQ_MASK: prdata_nxt[sdt_pkg::STAT_W-1:0] = mask_r;
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (paddr == sdt_pkg::CH_CFG0 + 8'(4 * i)) begin
                            prdata_nxt[sdt_pkg::CHCFG_W-1:0] = chcfg[i];
                        end
                        if (paddr == sdt_pkg::CH_VAL0 + 8'(4 * i)) begin
                            prdata_nxt[CNT_W-1:0] = chval[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            evn_r <= 1'b0;
            eva_r <= 1'b0;
            stat_r <= '0;
            mask_r <= '0;
            prdata_r <= '0;
        end else begin
            evn_r <= evn_nxt;
            eva_r <= eva_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            prdata_r <= prdata_nxt;
        end
    end
endmodule
`default_nettype wire

/* verification/sensor_domain_timers_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_domain_timers_properties #(
    parameter int NCH = 4
) (
    input wire logic clk, // Clock
    input wire logic rst, // Sync reset
    input wire logic psel, // APB select
    input wire logic penable, // APB access
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic en_24m, // Fast strobe
    input wire logic en_2m, // Medium strobe
    input wire logic en_32k, // Slow strobe
    input wire logic [NCH-1:0] cap_in, // Capture inputs
    input wire logic ev_engine, // Engine event
    input wire logic ev_adc, // ADC trigger
    input wire logic [NCH-1:0] wave_out, // Waveforms
    input wire logic irq // Interrupt
);
    logic acc;
    logic bad;
    logic cause;
    assign acc = psel && penable;
    assign bad = (paddr > 8'h48) || (paddr[1:0] != 2'b00);
    assign cause = en_24m || en_2m || en_32k || (|cap_in);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_PREADY_ZERO_WAIT: assert property (acc |-> pready)
        else $error("pready low in access phase");
    AST_SLVERR_BAD: assert property (acc && bad |-> pslverr)
        else $error("unmapped access not refused");
    AST_SLVERR_GOOD: assert property (acc && !bad |-> !pslverr)
        else $error("mapped access refused");
    AST_SLVERR_IDLE: assert property (!acc |-> !pslverr)
        else $error("pslverr outside access phase");
    // Read data only moves on a read setup
    AST_PRDATA_HOLD: assert property
        (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata changed without read setup");
    AST_RST_QUIET: assert property (disable iff (1'b0) rst |=>
        (!ev_engine && !ev_adc && !irq && wave_out == '0 && prdata == '0))
        else $error("outputs not quiet after reset");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(acc && pwrite &&
        (paddr == sdt_pkg::IRQ_STAT || paddr == sdt_pkg::IRQ_MASK)))
        else $error("irq dropped without status or mask write");
    AST_ENG_CAUSE: assert property (ev_engine |->
        ($past(cause, 2) || $past(cause, 3) || $past(cause, 4)))
        else $error("engine event without strobe or capture");
    AST_ADC_CAUSE: assert property (ev_adc |->
        ($past(cause, 2) || $past(cause, 3) || $past(cause, 4)))
        else $error("adc trigger without strobe or capture");
    AST_WAVE_CAUSE: assert property ($changed(wave_out) |->
        $past(rst || en_24m || en_2m || en_32k || (acc && pwrite)))
        else $error("wave output moved without tick or config write");

    cover property (ev_engine);
    cover property (ev_adc);
    cover property ($rose(irq));
    cover property (acc && pslverr);
endmodule
bind sensor_domain_timers sensor_domain_timers_properties #(.NCH(NCH)) i_props (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .en_24m(en_24m), .en_2m(en_2m), .en_32k(en_32k), .cap_in(cap_in),
    .ev_engine(ev_engine), .ev_adc(ev_adc), .wave_out(wave_out), .irq(irq)
);
`default_nettype wire

/* verification/sensor_event_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_event_sink (
    input wire logic clk, // System clock
    input wire logic rst, // Sync reset
    input wire logic ev_engine, // Engine event pulse
    input wire logic ev_adc, // ADC trigger pulse
    output logic [7:0] n_eng, // Engine events seen
    output logic [7:0] n_adc // ADC triggers seen
);
    logic [7:0] n_eng_r;
    logic [7:0] n_adc_r;
    // Count high cycles
    // A stuck level then shows up as extra events
    always_ff @(posedge clk) begin
        if (rst) begin
            n_eng_r <= 8'h00;
            n_adc_r <= 8'h00;
        end else begin
            n_eng_r <= n_eng_r + {7'h00, ev_engine};
            n_adc_r <= n_adc_r + {7'h00, ev_adc};
        end
    end
    assign n_eng = n_eng_r;
    assign n_adc = n_adc_r;
endmodule
`default_nettype wire

/* verification/sensor_domain_timers_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_domain_timers_tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err_q;
    logic en_24m, en_2m, en_32k, ev_engine, ev_adc, irq;
    logic [7:0] paddr, n_eng, n_adc;
    logic [31:0] pwdata, prdata, rd_q;
    logic [3:0] tick_src, cap_in, wave_out;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    sensor_domain_timers i_sensor_domain_timers (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tick_src(tick_src), .en_24m(en_24m),
        .en_2m(en_2m), .en_32k(en_32k), .cap_in(cap_in),
        .ev_engine(ev_engine), .ev_adc(ev_adc), .wave_out(wave_out),
        .irq(irq));
    sensor_event_sink i_sensor_event_sink (.clk(clk), .rst(rst),
        .ev_engine(ev_engine), .ev_adc(ev_adc), .n_eng(n_eng),
        .n_adc(n_adc));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Setup, then access held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, exp, rd_q);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One selected strobe per group, the other two follow as decoys
    task automatic pulse(input int n, input logic [2:0] on);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            {en_32k, en_2m, en_24m} <= on;
            @(posedge clk);
            {en_32k, en_2m, en_24m} <= ~on;
            @(posedge clk);
            {en_32k, en_2m, en_24m} <= 3'b000;
        end
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        tick_src = 4'h0;
        cap_in = 4'h0;
        en_24m = 1'b0;
        en_2m = 1'b0;
        en_32k = 1'b0;
        idle(16);
        rst <= 1'b0;
        rd("mask reset", sdt_pkg::IRQ_MASK, 32'h0000_0000);
        rd("unmapped data", 8'h4C, 32'h0000_0000);
        check("unmapped err", 32'h0000_0001, {31'h0000_0000, err_q});
        apb(1'b1, 8'h05, 32'h0000_0003);
        check("unaligned err", 32'h0000_0001, {31'h0000_0000, err_q});
        rd("t0 target", sdt_pkg::T0_TGT, 32'h0000_FFFF);
        // Timer 0: clock source, prescale 4, target 3, one-shot
        apb(1'b1, sdt_pkg::T0_TGT, 32'h0000_0003);
        apb(1'b1, sdt_pkg::T0_CFG, 32'h0000_0043);
        idle(40);
        rd("t0 count", sdt_pkg::T0_CNT, 32'h0001_0003);
        rd("status t0", sdt_pkg::IRQ_STAT, 32'h0000_0001);
        check("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
        apb(1'b1, sdt_pkg::IRQ_MASK, 32'h0000_0001);
        idle(1);
        check("irq unmasked", 32'h0000_0001, {31'h0000_0000, irq});
        apb(1'b1, sdt_pkg::IRQ_STAT, 32'h0000_0001);
        idle(1);
        check("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
        // Timer 1: edges of tick 2, prescale 2; tick 0 toggles as decoy
        apb(1'b1, sdt_pkg::T1_TGT, 32'h0000_00FF);
        apb(1'b1, sdt_pkg::T1_CFG, 32'h0000_0035);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            tick_src <= tick_src ^ 4'h5;
            idle(1);
        end
        idle(3);
        rd("t1 count", sdt_pkg::T1_CNT, 32'h0000_0005);
        // Timer 2 on the 2 MHz strobe, target 2, channel 0 compares at 1
        apb(1'b1, sdt_pkg::CH_CFG0, 32'h0000_0001);
        apb(1'b1, sdt_pkg::CH_VAL0, 32'h0000_0001);
        apb(1'b1, sdt_pkg::CH_CFG0 + sdt_pkg::REG_STRIDE, 32'h0000_0003);
        apb(1'b1, sdt_pkg::T2_TGT, 32'h0000_0002);
        apb(1'b1, sdt_pkg::T2_CFG, 32'h0000_0005);
        pulse(7, 3'b010);
        idle(6);
        rd("t2 count", sdt_pkg::T2_CNT, 32'h0000_0001);
        check("pwm out", 32'h0000_0001, {31'h0000_0000, wave_out[0]});
        check("engine events", 32'h0000_0002, {24'h00_0000, n_eng});
        check("adc triggers", 32'h0000_0002, {24'h00_0000, n_adc});
        rd("status t2", sdt_pkg::IRQ_STAT, 32'h0000_000C);
        @(posedge clk);
        cap_in <= 4'h2;
        idle(4);
        rd("capture", sdt_pkg::CH_VAL0 + 8'h04, 32'h0000_0001);
        rd("status cap", sdt_pkg::IRQ_STAT, 32'h0000_001C);
        // 24 MHz strobe; channel 2 one-shot toggle at 0 feeds the engine,
        // channel 0 feeds the ADC
        apb(1'b1, sdt_pkg::CH_CFG0 + 8'h08, 32'h0000_000D);
        apb(1'b1, sdt_pkg::CH_VAL0 + 8'h08, 32'h0000_0000);
        apb(1'b1, sdt_pkg::T2_CFG, 32'h0000_0021);
        pulse(5, 3'b001);
        idle(2);
        rd("t2 count 24m", sdt_pkg::T2_CNT, 32'h0000_0002);
        check("waves", 32'h0000_0004, {28'h000_0000, wave_out});
        check("engine routed", 32'h0000_0003, {24'h00_0000, n_eng});
        check("adc routed", 32'h0000_0004, {24'h00_0000, n_adc});
        rd("status ch2", sdt_pkg::IRQ_STAT, 32'h0000_003C);
        @(posedge clk);
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        rd("t2 target", sdt_pkg::T2_TGT, 32'h0000_FFFF);
        rd("t2 cleared", sdt_pkg::T2_CNT, 32'h0000_0000);
        wrap_up();
    end
endmodule
`default_nettype wire
